// ### e3_irq_cfg.svh
// Register offsets, field positions and reset values of the receive interrupt block.
`ifndef E3_IRQ_CFG_SVH
`define E3_IRQ_CFG_SVH

`define OFS_DEFECT_STATE  8'h11
`define OFS_IRQ_ENABLE    8'h13
`define OFS_IRQ_FLAGS     8'h15
`define OFS_TRACE_FIRST   8'h1C
`define OFS_TRACE_LAST    8'h2B

`define BIT_REMOTE_STATE  0
`define BIT_FAIL_IRQ      3
`define BIT_BLOCK_ERR_IRQ 4
`define BIT_TRACE_IRQ     6
`define BIT_LOSS_ALGO     7

`define RST_BYTE          8'h00
`define TRACE_LEN         16
`define TRACE_AW          4

`endif

// ### e3_irq_chk.sv
// Port-level checks of the receive interrupt block.
`timescale 1ns/1ps
module e3_irq_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Framer overhead
    input wire logic       frame_valid,
    input wire logic       maint_fail_bit,
    input wire logic       maint_block_err_bit,
    input wire logic       trace_msg_done,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic       irq_n,
    input wire logic       frame_loss_algorithm_select
);
    logic [7:0] en;
    logic       fail;
    logic [5:0] since_done;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) en <= 8'h00;
        else if (reg_wr && reg_addr == 8'h13) en <= reg_wdata & 8'h58;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) fail <= 1'b0;
        else if (frame_valid) fail <= maint_fail_bit;
    end
    // Saturates so that a long-idle trace path reads as quiet.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) since_done <= 6'h3F;
        else if (trace_msg_done) since_done <= 6'h00;
        else if (since_done != 6'h3F) since_done <= since_done + 6'h01;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_block_err_pin: assert property (frame_valid && maint_block_err_bit && en[4] |=> ##[0:1] !irq_n)
        else $error("block error left the pin high");
    a_fail_change_pin: assert property (frame_valid && maint_fail_bit != fail && en[3] |=> ##[0:1] !irq_n)
        else $error("failure change left the pin high");
    a_state_read: assert property (reg_rd && reg_addr == 8'h11 && !frame_valid |=> reg_rdata[0] == fail
        && reg_rdata[7] == frame_loss_algorithm_select) else $error("state register read wrong");
    a_enable_read: assert property (reg_rd && reg_addr == 8'h13 |=> reg_rdata == en)
        else $error("enable register read wrong");
    a_masked_quiet: assert property (en == 8'h00 && $past(en) == 8'h00 |-> irq_n)
        else $error("pin low with every source disabled");
    a_read_release: assert property ((reg_rd && reg_addr == 8'h15 && !frame_valid && since_done == 6'h3F)
        ##1 !frame_valid |-> ##[0:1] irq_n) else $error("pin stayed low after status read");
    a_pin_cause: assert property ($fell(irq_n) |-> $past(frame_valid) || $past(frame_valid, 2)
        || $past(reg_wr) || (since_done >= 6'd30 && since_done <= 6'd36)) else $error("pin fell without cause");
    a_block_err_flag: assert property (frame_valid && maint_block_err_bit && en[4] ##[1:3]
        (reg_rd && reg_addr == 8'h15) |=> reg_rdata[4]) else $error("block error flag not set");
    a_fail_flag: assert property (frame_valid && maint_fail_bit != fail && en[3] ##[1:3]
        (reg_rd && reg_addr == 8'h15) |=> reg_rdata[3]) else $error("failure flag not set");
    c_block_err: cover property (frame_valid && maint_block_err_bit && en[4]);
    c_trace_flag: cover property (reg_rd && reg_addr == 8'h15 ##1 reg_rdata[6]);
    c_fail_rise: cover property ($rose(fail) && en[3]);
endmodule
bind e3_rx_trace_remote_alarm_irq e3_irq_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .frame_valid(frame_valid),
    .maint_fail_bit(maint_fail_bit), .maint_block_err_bit(maint_block_err_bit), .trace_msg_done(trace_msg_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_n(irq_n), .frame_loss_algorithm_select(frame_loss_algorithm_select));

// ### e3_irq_pkg.sv
// Types shared by the receive interrupt block.
package e3_irq_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        CAP_IDLE    = 2'b00,
        CAP_COMPARE = 2'b01,
        CAP_COMMIT  = 2'b10
    } cap_state_e;
endpackage

// ### e3_rx_trace_remote_alarm_irq.sv
// Receive interrupt logic for trace change, far-end failure and far-end block error.
// How it works
// - A captured trace message that differs from the stored one raises a trace-change event when enabled.
// - Bit 6 of the enable register at 0x13 enables the trace-change interrupt.
// - Any enabled event drives the active-low interrupt pin low.
// - A trace-change event sets bit 6 of the status register at 0x15.
// - The new trace message is stored in the sixteen byte registers at 0x1C to 0x2B.
// - The far-end failure interrupt fires on both declare and clear of the condition.
// - The failure condition is declared when frames arrive with the failure bit of the maintenance byte set.
// - The failure condition is cleared when frames arrive with that bit clear.
// - Bit 3 of the enable register enables the far-end failure interrupt.
// - A far-end failure event sets bit 3 of the status register.
// - Bit 0 of the register at 0x11 shows the present far-end failure state, read only.
// - Each frame with the block error bit of the maintenance byte set raises a block error event when enabled.
// - Bit 4 of the enable register enables the block error interrupt.
// - A block error event sets bit 4 of the status register.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "e3_irq_cfg.svh"
module e3_rx_trace_remote_alarm_irq
    import e3_irq_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Framer overhead
    input  wire logic       frame_valid,
    input  wire logic       maint_fail_bit,
    input  wire logic       maint_block_err_bit,
    input  wire logic       trace_byte_valid,
    input  wire logic [3:0] trace_byte_index,
    input  wire logic [7:0] trace_byte,
    input  wire logic       trace_msg_done,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Interrupt and state
    output logic            irq_n,
    output logic            frame_loss_algorithm_select
);
    ////////////////////////////////////////////////////////////////////////////////
    trace_mem_if mem_bus ();

    trace_store u_store (
        .clk_sys (clk_sys),
        .bus     (mem_bus)
    );

    function automatic logic is_trace_addr(input logic [7:0] a);
        return (a >= `OFS_TRACE_FIRST) && (a <= `OFS_TRACE_LAST);
    endfunction

    logic [7:0] irq_enable;
    logic [7:0] irq_flags;
    logic       remote_failure_state;
    logic [7:0] pending    [`TRACE_LEN];
    logic [`TRACE_LEN-1:0] pend_diff;
    cap_state_e cap_state;
    logic [3:0] cap_idx;
    logic       store_valid;
    logic       trace_event;
    logic       fail_event;
    logic       block_err_event;
    logic       rd_trace_q;
    logic       rd_other_q;
    logic [7:0] rd_word_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Incoming trace bytes are gathered here so the stored copy stays stable until a
    // whole message is in and known to differ.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `TRACE_LEN; i++) begin
                pending[i] <= `RST_BYTE;
            end
        end else if (trace_byte_valid && cap_state == CAP_IDLE) begin
            pending[trace_byte_index] <= trace_byte;
        end
    end

    // Compare pass walks the store one byte per cycle through its registered read.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_state   <= CAP_IDLE;
            cap_idx     <= '0;
        end else begin
            case (cap_state)
                CAP_IDLE: begin
                    cap_idx     <= '0;
                    if (trace_msg_done) begin
                        cap_state <= CAP_COMPARE;
                    end
                end
                CAP_COMPARE: begin
                    cap_idx <= cap_idx + 4'h1;
                    if (cap_idx == 4'hF) begin
                        cap_state <= CAP_COMMIT;
                    end
                end
                CAP_COMMIT: begin
                    if (cap_idx == 4'hF) begin
                        cap_state <= CAP_IDLE;
                    end else begin
                        cap_idx <= cap_idx + 4'h1;
                    end
                end
                default: cap_state <= CAP_IDLE;
            endcase
        end
    end

    // One flag per byte from the compare pass; byte k is compared one cycle after its read.
    logic [3:0] cmp_idx_q;
    logic       cmp_valid_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmp_idx_q   <= '0;
            cmp_valid_q <= 1'b0;
        end else begin
            cmp_idx_q   <= cap_idx;
            cmp_valid_q <= (cap_state == CAP_COMPARE);
        end
    end

    genvar g;
    generate
        for (g = 0; g < `TRACE_LEN; g++) begin : g_diff
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pend_diff[g] <= 1'b0;
                end else if (cap_state == CAP_IDLE && trace_msg_done) begin
                    pend_diff[g] <= 1'b0;
                end else if (cmp_valid_q && cmp_idx_q == 4'(g) && mem_bus.rd_data != pending[g]) begin
                    pend_diff[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // The last compare result lands on the second commit cycle, so the OR is taken in the commit state.
    logic any_diff;

    // The store powers up unknown and an unknown compare never flags, so the first whole
    // message after reset always counts as a change.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            store_valid <= 1'b0;
        end else if (trace_event) begin
            store_valid <= 1'b1;
        end
    end

    assign any_diff = (|pend_diff) || !store_valid;

    always_comb begin
        mem_bus.wr_en   = (cap_state == CAP_COMMIT) && any_diff;
        mem_bus.wr_addr = cap_idx;
        mem_bus.wr_data = pending[cap_idx];
        mem_bus.rd_addr = (cap_state == CAP_COMPARE) ? cap_idx : 4'(reg_addr - `OFS_TRACE_FIRST);
    end

    assign trace_event = (cap_state == CAP_COMMIT) && (cap_idx == 4'hF) && any_diff;

    ////////////////////////////////////////////////////////////////////////////////
    // declare on bit set
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            remote_failure_state <= 1'b0;
        end else if (frame_valid) begin
            remote_failure_state <= maint_fail_bit;
        end
    end

    assign fail_event      = frame_valid && (maint_fail_bit != remote_failure_state);
    assign block_err_event = frame_valid && maint_block_err_bit;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt enables and frame loss algorithm select
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable                  <= `RST_BYTE;
            frame_loss_algorithm_select <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `OFS_IRQ_ENABLE) begin
                irq_enable[`BIT_TRACE_IRQ]     <= reg_wdata[`BIT_TRACE_IRQ];
                irq_enable[`BIT_BLOCK_ERR_IRQ] <= reg_wdata[`BIT_BLOCK_ERR_IRQ];
                irq_enable[`BIT_FAIL_IRQ]      <= reg_wdata[`BIT_FAIL_IRQ];
            end
            if (reg_addr == `OFS_DEFECT_STATE) begin
                frame_loss_algorithm_select <= reg_wdata[`BIT_LOSS_ALGO];
            end
        end
    end

    // Set wins over the clear so an event in the read cycle is kept for the next read.
    logic flags_read;
    logic [7:0] set_mask;
    assign flags_read = reg_rd && (reg_addr == `OFS_IRQ_FLAGS);
    always_comb begin
        set_mask = `RST_BYTE;
        set_mask[`BIT_TRACE_IRQ]     = trace_event && irq_enable[`BIT_TRACE_IRQ];
        set_mask[`BIT_FAIL_IRQ]      = fail_event && irq_enable[`BIT_FAIL_IRQ];
        set_mask[`BIT_BLOCK_ERR_IRQ] = block_err_event && irq_enable[`BIT_BLOCK_ERR_IRQ];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags <= `RST_BYTE;
        end else if (flags_read) begin
            irq_flags <= set_mask;
        end else begin
            irq_flags <= irq_flags | set_mask;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~(|(set_mask | (flags_read ? `RST_BYTE : irq_flags & irq_enable)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trace bytes come out of the store a cycle later, so the read word is chosen then.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_trace_q <= 1'b0;
            rd_other_q <= 1'b0;
            rd_word_q  <= `RST_BYTE;
        end else begin
            rd_trace_q <= reg_rd && is_trace_addr(reg_addr);
            rd_other_q <= reg_rd && !is_trace_addr(reg_addr);
            case (reg_addr)
                `OFS_DEFECT_STATE: rd_word_q <= {frame_loss_algorithm_select, 6'h00, remote_failure_state};
                `OFS_IRQ_ENABLE:   rd_word_q <= irq_enable;
                `OFS_IRQ_FLAGS:    rd_word_q <= irq_flags;
                default:           rd_word_q <= `RST_BYTE;
            endcase
        end
    end

    // A trace read that meets a compare pass returns the byte at the compare index; software reads after the interrupt.
    always_comb begin
        if (rd_trace_q) begin
            reg_rdata = mem_bus.rd_data;
        end else if (rd_other_q) begin
            reg_rdata = rd_word_q;
        end else begin
            reg_rdata = `RST_BYTE;
        end
    end
endmodule

// ### host_agent.sv
// Host processor model driving the register port with one-cycle strobes.
`timescale 1ns/1ps
module host_agent (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Data is only valid in the cycle after the strobe, so it is taken just past that edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic read_trace(output logic [7:0] m [16]);
        for (int i = 0; i < 16; i++) rd(8'h1C + 8'(i), m[i]);
    endtask
endmodule

// ### test_e3_rx_trace_remote_alarm_irq.sv
// Self-checking bench for the receive interrupt block.
`timescale 1ns/1ps
module test_e3_rx_trace_remote_alarm_irq;
    logic       clk_sys, rst_n, frame_valid, maint_fail_bit, maint_block_err_bit;
    logic       trace_byte_valid, trace_msg_done, reg_wr, reg_rd, irq_n, frame_loss_algorithm_select;
    logic [3:0] trace_byte_index;
    logic [7:0] trace_byte, reg_addr, reg_wdata, reg_rdata, d;
    logic [7:0] msg [16];
    int         miscompares, total_checks, cycles;
    e3_rx_trace_remote_alarm_irq u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .frame_valid(frame_valid),
        .maint_fail_bit(maint_fail_bit), .maint_block_err_bit(maint_block_err_bit),
        .trace_byte_valid(trace_byte_valid), .trace_byte_index(trace_byte_index), .trace_byte(trace_byte),
        .trace_msg_done(trace_msg_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_n(irq_n), .frame_loss_algorithm_select(frame_loss_algorithm_select));
    host_agent u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out;
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input int i, input logic [3:0] k);
        return (i == 15) ? {k, 4'hF} : {4'hA, 4'(i)};
    endfunction
    // Maintenance bits are inverted outside the frame strobe so stale values never pass.
    task automatic frame(input logic f, input logic b);
        @(posedge clk_sys);
        frame_valid <= 1'b1;
        maint_fail_bit <= f;
        maint_block_err_bit <= b;
        @(posedge clk_sys);
        frame_valid <= 1'b0;
        maint_fail_bit <= ~f;
        maint_block_err_bit <= ~b;
        @(posedge clk_sys);
        #1;
    endtask
    // The fixed wait covers the 32-cycle compare and commit pass with some margin.
    task automatic send_msg(input logic [3:0] k);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            trace_byte_valid <= 1'b1;
            trace_byte_index <= 4'(i);
            trace_byte <= exp_byte(i, k);
        end
        @(posedge clk_sys);
        trace_byte_valid <= 1'b0;
        trace_byte <= ~trace_byte;
        trace_msg_done <= 1'b1;
        @(posedge clk_sys);
        trace_msg_done <= 1'b0;
        repeat (40) @(posedge clk_sys);
        #1;
    endtask
    task automatic service(input logic [7:0] e15, input logic [7:0] e11);
        u_host.rd(8'h15, d);
        chk_byte(d, e15);
        u_host.rd(8'h11, d);
        chk_byte(d, e11);
        u_host.rd(8'h15, d);
        chk_byte(d, 8'h00);
        chk_bit(irq_n, 1'b1);
    endtask
    task automatic check_trace(input logic [3:0] k);
        u_host.read_trace(msg);
        for (int i = 0; i < 16; i++) chk_byte(msg[i], exp_byte(i, k));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, frame_valid, maint_fail_bit, maint_block_err_bit, trace_byte_valid, trace_msg_done} = 6'h00;
        trace_byte_index = 4'h0;
        trace_byte = 8'h00;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_bit(irq_n, 1'b1);
        service(8'h00, 8'h00);
        u_host.rd(8'h50, d);
        chk_byte(d, 8'h00);
        u_host.wr(8'h13, 8'hFF);
        u_host.rd(8'h13, d);
        chk_byte(d, 8'h58);
        u_host.wr(8'h11, 8'h81);
        chk_bit(frame_loss_algorithm_select, 1'b1);
        frame(1'b0, 1'b1);
        chk_bit(irq_n, 1'b0);
        service(8'h10, 8'h80);
        frame(1'b1, 1'b1);
        chk_bit(irq_n, 1'b0);
        service(8'h18, 8'h81);
        frame(1'b1, 1'b0);
        chk_bit(irq_n, 1'b1);
        frame(1'b0, 1'b0);
        chk_bit(irq_n, 1'b0);
        service(8'h08, 8'h80);
        u_host.wr(8'h13, 8'h00);
        frame(1'b1, 1'b1);
        chk_bit(irq_n, 1'b1);
        service(8'h00, 8'h81);
        frame(1'b0, 1'b0);
        u_host.wr(8'h13, 8'h40);
        send_msg(4'h1);
        chk_bit(irq_n, 1'b0);
        service(8'h40, 8'h80);
        check_trace(4'h1);
        send_msg(4'h1);
        chk_bit(irq_n, 1'b1);
        send_msg(4'h2);
        chk_bit(irq_n, 1'b0);
        service(8'h40, 8'h80);
        check_trace(4'h2);
        close_out();
    end
endmodule

// ### trace_mem_if.sv
// Port bundle between the interrupt logic and the trace message store.
`timescale 1ns/1ps
interface trace_mem_if;
    logic       wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### trace_store.sv
// Sixteen-byte store for the received trail trace message, registered read.
`timescale 1ns/1ps
`include "e3_irq_cfg.svh"
module trace_store (
    // Clock
    input wire logic clk_sys,
    // Access
    trace_mem_if.mem bus
);
    logic [7:0] cells [`TRACE_LEN];

    always_ff @(posedge clk_sys) begin
        if (bus.wr_en) begin
            cells[bus.wr_addr] <= bus.wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        bus.rd_data <= cells[bus.rd_addr];
    end
endmodule
